// file: hdl/ttl_pkg.sv
// ****************************************************************
// shared types and constants for the thermal trip latch
// ****************************************************************
package ttl_pkg;

   // sensor synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;

   // reset values of the latch and clock gate
   localparam logic TRIP_RST    = 1'h0;
   localparam logic CLK_RUN_RST = 1'h1;

   // trip threshold in degrees celsius, for reference only
   localparam int unsigned TRIP_DEG_C = 135;

   // latch states, gray coded along idle -> tripped
   typedef enum logic [0:0] {
      TTL_IDLE    = 1'h0,
      TTL_TRIPPED = 1'h1
   } ttl_state_t;

   // status carried to the outside world
   typedef struct packed {
      logic overtemp_shutdown_n;  // active-low trip pin
      logic core_clk_en;          // enable for all internal clocks
      logic tripped;              // latch state as a level
   } ttl_status_t;

endpackage : ttl_pkg

// file: hdl/ttl_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// two-stage level synchroniser for the sensor trip indication
// ****************************************************************
module ttl_sync (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   import ttl_pkg::*;

   logic [SYNC_STAGES-1:0] stage_r;

   // first stage is read only by the second
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stage_r <= '0;
      end else begin
         stage_r <= {stage_r[SYNC_STAGES-2:0], din};
      end
   end

   assign dout = stage_r[SYNC_STAGES-1];

endmodule // ttl_sync

// file: hdl/ttl_top.sv
`timescale 1ns/1ps
module ttl_top (
   input  wire logic            mclk,
   input  wire logic            rstn,
   input  wire logic            sensor_trip,
   output ttl_pkg::ttl_status_t status
);
   import ttl_pkg::*;

   ttl_state_t state_r;
   ttl_state_t state_nxt;
   logic       trip_sync;
   // output flops, one per concern
   logic       shutdown_n_r;  // trip pin, active low
   logic       clk_en_r;      // enable for all internal clocks
   logic       tripped_r;     // latch state as a level

   // ****************************************************************
   // state decode
   // ****************************************************************
   // one decode for pin, clock gate and level, so that the three
   // outputs cannot drift apart
   function automatic logic is_tripped(input ttl_state_t s);
      return (s == TTL_TRIPPED);
   endfunction

   // ****************************************************************
   // sensor synchroniser
   // ****************************************************************
   // avoids a glitching pin or clock gate from an async sensor
   // the sensor may change at any time, so it never meets logic raw
   ttl_sync u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .din  (sensor_trip),
      .dout (trip_sync)
   );

   // ****************************************************************
   // trip latch
   // ****************************************************************
   // next state: set on synced trip, hold until reset
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TTL_IDLE: begin
            if (trip_sync) begin
               state_nxt = TTL_TRIPPED;
            end
         end
         TTL_TRIPPED: begin
            state_nxt = TTL_TRIPPED;
         end
         default: begin
            state_nxt = TTL_IDLE;
         end
      endcase
   end

   // only rstn clears; a still-hot sensor re-sets after release
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= TTL_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   // trip pin, driven low while the latch is set
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shutdown_n_r <= ~TRIP_RST;
      end else begin
         shutdown_n_r <= ~is_tripped(state_nxt);
      end
   end

   // gate for all internal clocks; low halts execution
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clk_en_r <= CLK_RUN_RST;
      end else begin
         clk_en_r <= ~is_tripped(state_nxt);
      end
   end

   // latch state as a plain level
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tripped_r <= TRIP_RST;
      end else begin
         tripped_r <= is_tripped(state_nxt);
      end
   end

   // gather the flops into the status word
   assign status = '{
      overtemp_shutdown_n: shutdown_n_r,
      core_clk_en:         clk_en_r,
      tripped:             tripped_r
   };

   // ****************************************************************
   // checks
   // ****************************************************************
   // sensor seen hot after the synchroniser
   sequence s_hot;
      trip_sync;
   endsequence

   // trip pin asserted
   sequence s_pin_low;
      !status.overtemp_shutdown_n;
   endsequence

   // a synced trip pulls the pin one edge later
   chk_trip_sets_pin: assert property (
      @(posedge mclk) disable iff (!rstn)
      s_hot |=> s_pin_low)
      else $error("trip pin not asserted after sensor trip");

   // no clock may run while the pin is low
   chk_clock_stops: assert property (
      @(posedge mclk) disable iff (!rstn)
      !status.overtemp_shutdown_n |-> !status.core_clk_en)
      else $error("clocks running while trip asserted");

   // only reset lets go of the pin
   chk_latch_holds: assert property (
      @(posedge mclk) disable iff (!rstn)
      s_pin_low |=> s_pin_low)
      else $error("trip released without reset");

   // a sensor held hot out of reset trips again; the release edge
   // itself is left out, the flops still see reset there
   chk_retrip_bound: assert property (
      @(posedge mclk) disable iff (!rstn)
      (rstn && sensor_trip) [*3] |-> ##[0:1] s_pin_low)
      else $error("no retrip while sensor held hot");

   // the latch never sets ahead of the synchroniser
   chk_sync_delay: assert property (
      @(posedge mclk) disable iff (!rstn)
      $rose(status.tripped) |-> $past(sensor_trip, 3))
      else $error("trip set without synchronised sensor");

   // clock gate and pin move together
   chk_clk_level_tie: assert property (
      @(posedge mclk) disable iff (!rstn)
      status.core_clk_en == status.overtemp_shutdown_n)
      else $error("clock enable and trip pin disagree");

   // the level output is the pin turned over
   chk_level_pin_tie: assert property (
      @(posedge mclk) disable iff (!rstn)
      status.tripped != status.overtemp_shutdown_n)
      else $error("trip level and trip pin disagree");

   // a synced trip stops the clocks one edge later
   chk_clk_stop_latency: assert property (
      @(posedge mclk) disable iff (!rstn)
      s_hot |=> !status.core_clk_en)
      else $error("clocks not stopped after sensor trip");

   // ****************************************************************
   // checks: latency and reset
   // ****************************************************************
   // trip pin released
   sequence s_pin_high;
      status.overtemp_shutdown_n;
   endsequence

   // sensor quiet for three edges, out of reset
   sequence s_sensor_cold;
      (rstn && !sensor_trip) [*3];
   endsequence

   // first hot sample while the latch is still clear
   sequence s_sensor_rise;
      rstn && sensor_trip && status.overtemp_shutdown_n;
   endsequence

   // pin stays high two more edges, then falls: two sync flops and
   // the output flop, no earlier and no later
   chk_trip_latency: assert property (
      @(posedge mclk) disable iff (!rstn)
      s_sensor_cold ##1 s_sensor_rise |=> s_pin_high [*2] ##1 s_pin_low)
      else $error("trip pin fell at the wrong edge");

   // three quiet edges leave a clear latch clear
   chk_cool_stays_idle: assert property (
      @(posedge mclk) disable iff (!rstn)
      s_sensor_cold ##0 s_pin_high |=> s_pin_high)
      else $error("trip pin fell with a cool sensor");

   // reset puts every output at its idle value; looked at one edge
   // on, so the very first edge of a run is left alone
   chk_reset_idle: assert property (
      @(posedge mclk)
      !rstn |=> (status.overtemp_shutdown_n && status.core_clk_en
                 && !status.tripped))
      else $error("outputs not cleared by reset");

   // a stopped clock stays stopped until reset
   chk_clk_gate_holds: assert property (
      @(posedge mclk) disable iff (!rstn)
      !status.core_clk_en |=> !status.core_clk_en)
      else $error("internal clocks restarted without reset");

   // the synchroniser is exactly two flops deep
   chk_sync_depth: assert property (
      @(posedge mclk) disable iff (!rstn)
      $past(rstn, 2) |-> (trip_sync == $past(sensor_trip, 2)))
      else $error("sensor synchroniser depth wrong");

endmodule // ttl_top

// file: tb/ttl_power_ctl.sv
`timescale 1ns/1ps
// ****
// platform power control
// ****
module ttl_power_ctl (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic overtemp_shutdown_n,
   output logic      power_off
);
   // supply is cut on trip and held off until reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) power_off <= 1'h0;
      else if (!overtemp_shutdown_n) power_off <= 1'h1;
   end
endmodule // ttl_power_ctl

// file: tb/tb_top.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
   import ttl_pkg::*;
   logic        mclk, rstn, sensor_trip, power_off;
   ttl_status_t status;
   logic [15:0] lf;
   int          n_mismatch, n_tests;
   ttl_top DUT (.mclk(mclk), .rstn(rstn), .sensor_trip(sensor_trip),
      .status(status));
   ttl_power_ctl PWR (.mclk(mclk), .rstn(rstn),
      .overtemp_shutdown_n(status.overtemp_shutdown_n),
      .power_off(power_off));
   // clock and watchdog
   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // expected status for a latch that is set or clear
   function automatic ttl_status_t exp_st(input logic hot);
      return hot ? 3'h1 : 3'h6;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic hot, input logic p);
      n_tests++;
      if (status !== exp_st(hot) || power_off !== p) begin
         n_mismatch++;
         $display("ERROR status exp %h/%b got %h/%b", exp_st(hot), p,
            status, power_off);
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // main sequence
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      lf = 16'h4D4C;
      rstn = 1'h0;
      sensor_trip = 1'h0;
      repeat (12) @(posedge mclk);
      rstn <= 1'h1;
      cyc(1 + lf[3:0]);
      chk(1'h0, 1'h0);
      @(posedge mclk) sensor_trip <= 1'h1;
      cyc(2);
      chk(1'h0, 1'h0);
      cyc(1);
      chk(1'h1, 1'h0);
      cyc(1);
      chk(1'h1, 1'h1);
      repeat (16) begin
         @(posedge mclk) sensor_trip <= lf[0];
         lf = lfsr(lf);
      end
      @(posedge mclk) sensor_trip <= 1'h0;
      cyc(3);
      chk(1'h1, 1'h1);
      $display("test trip and latch done");
      @(posedge mclk) rstn <= 1'h0;
      sensor_trip <= 1'h1;
      #1;
      chk(1'h0, 1'h0);
      cyc(2);
      @(posedge mclk) rstn <= 1'h1;
      cyc(2);
      chk(1'h0, 1'h0);
      cyc(1);
      chk(1'h1, 1'h0);
      $display("test retrip done");
      @(posedge mclk) rstn <= 1'h0;
      sensor_trip <= 1'h0;
      cyc(1);
      @(posedge mclk) rstn <= 1'h1;
      cyc(4 + lf[2:0]);
      chk(1'h0, 1'h0);
      $display("test cool reset done");
      test_done();
   end
endmodule // tb_top
